// ### verilog/erc_top.sv
/*
 Configuration, locking and mode gating of an auxiliary PNP regulator.
 Assumes a power-on reset, the chip mode from the mode controller on the
 same clock, and analog sense levels arriving asynchronously.
*/
// Strobed register access and the placing of the registers are this design's own decisions.
// Operation
// - Enable write in Normal mode picks stand-alone configuration.
// - Load-share select bit picks load-sharing configuration.
// - First chosen configuration stays locked until power is removed.
// - Stand-alone: level bit picks 5.0V or 3.3V; ignored when sharing.
// - Stand-alone: off in INIT/Fail-Safe, set in Normal, held elsewhere.
// - Sharing: off INIT/Sleep/Fail-Safe, on in Restart and Normal.
// - Stop turns sharing off unless stop-keep-on; select bit stays set.
// - Supply undervoltage switches off unless uv-keep-on is set.
// - Stand-alone: on/off accepted, config change ignored silently.
// - Sharing locked: config change sets failure flag, no change.
// - Stand-alone overcurrent limits and sets flag; clear when gone.
// - Stand-alone output undervoltage sets undervoltage flag.
// - Sharing sets neither undervoltage nor overcurrent flag.
// - Stop: high-power stage on above rise, off below fall threshold.
// - Normal: high-power stage only, low-power stage unused.
`timescale 1ns/1ns
`include "erc_defines.svh"
module erc_top
	import erc_pkg::*;
(
	input  wire logic                   i_core_clk,
	input  wire logic                   i_sys_rst,
	input  wire logic [2:0]             i_chip_mode,
	input  wire erc_sense_s             i_sense,
	input  wire logic [`ERC_ADDR_W-1:0] i_addr,
	input  wire logic [7:0]             i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [7:0]             o_rdata,
	output erc_drive_s                  o_drive
);
	erc_sense_s sense_s;
	erc_cfg_e   cfg_r;
	logic       on_r;
	logic       lvl_r;
	logic       ls_r;
	logic       stpon_r;
	logic       uvon_r;
	logic       oc_r;
	logic       uv_r;
	logic       fail_r;
	logic       hp_on;
	erc_mode_e  mode;

	// Synchronise the analog sense levels
	erc_sync #(.WIDTH(5)) u_sync (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.i_async    (i_sense),
		.o_sync     (sense_s)
	);

	assign mode = erc_mode_e'(i_chip_mode);

	// Register write decode
	wire wr_ctrl  = i_wr && (i_addr == `ERC_OFF_CTRL);
	wire wr_hw    = i_wr && (i_addr == `ERC_OFF_HWCTRL);
	wire wr_stat  = i_wr && (i_addr == `ERC_OFF_STAT);
	wire in_norm  = (mode == ERC_MODE_NORMAL);
	wire w_on     = i_wdata[`ERC_CTRL_ON_BIT];
	wire w_ls     = i_wdata[`ERC_HW_LS_BIT];
	wire is_stand = (cfg_r == ERC_CFG_STAND);
	wire is_share = (cfg_r == ERC_CFG_SHARE);

	// Configuration selection and change attempts
	wire pick_stand = wr_ctrl && w_on && in_norm && (cfg_r == ERC_CFG_NONE);
	wire pick_share = wr_hw && w_ls && (cfg_r == ERC_CFG_NONE);
	wire try_ls     = wr_hw && (w_ls != ls_r);
	wire try_on     = wr_ctrl && w_on;
	wire chg_share  = is_share && (try_ls || try_on);

	// Configuration lock, cleared only by power-on reset
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cfg_r <= ERC_CFG_NONE;
		end else if (pick_share) begin
			cfg_r <= ERC_CFG_SHARE;
		end else if (pick_stand) begin
			cfg_r <= ERC_CFG_STAND;
		end
	end

	// Control bits; the select bit sticks once sharing is locked
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			on_r    <= 1'b0;
			lvl_r   <= 1'b0;
			ls_r    <= 1'b0;
			stpon_r <= 1'b0;
			uvon_r  <= 1'b0;
		end else begin
			if (wr_ctrl && in_norm && !is_share && !pick_share) begin
				on_r  <= w_on;
				lvl_r <= i_wdata[`ERC_CTRL_LVL_BIT];
			end
			if (pick_share) begin
				ls_r <= 1'b1;
			end
			if (wr_hw) begin
				stpon_r <= i_wdata[`ERC_HW_STPON_BIT];
				uvon_r  <= i_wdata[`ERC_HW_UVON_BIT];
			end
		end
	end

	// Status flags: hardware set wins over software clear
	wire oc_clr = wr_stat && i_wdata[`ERC_STAT_OC_BIT] && !sense_s.shunt_hit;
	wire uv_clr = wr_stat && i_wdata[`ERC_STAT_UV_BIT];
	wire fl_clr = wr_stat && i_wdata[`ERC_STAT_FAIL_BIT];
	wire oc_set = is_stand && sense_s.shunt_hit;
	wire uv_set = is_stand && sense_s.out_uv;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			oc_r   <= 1'b0;
			uv_r   <= 1'b0;
			fail_r <= 1'b0;
		end else begin
			oc_r   <= oc_set | (oc_r & ~oc_clr);
			uv_r   <= uv_set | (uv_r & ~uv_clr);
			fail_r <= chg_share | (fail_r & ~fl_clr);
		end
	end

	// Mode gating of the regulator enable
	logic mode_on;
	always_comb begin
		mode_on = 1'b0;
		if (is_stand) begin
			case (mode)
				ERC_MODE_INIT:    mode_on = 1'b0;
				ERC_MODE_FAIL:    mode_on = 1'b0;
				default:          mode_on = on_r;
			endcase
		end else if (is_share) begin
			case (mode)
				ERC_MODE_NORMAL:  mode_on = ls_r;
				ERC_MODE_STOP:    mode_on = ls_r && stpon_r;
				ERC_MODE_RESTART: mode_on = 1'b1;
				default:          mode_on = 1'b0;
			endcase
		end
	end
	wire en_nxt = mode_on && (!sense_s.supply_uv || uvon_r);

	// Stop-mode high-power stage hysteresis
	erc_hyst u_hyst (
		.i_core_clk   (i_core_clk),
		.i_sys_rst    (i_sys_rst),
		.i_stop       (mode == ERC_MODE_STOP),
		.i_above_rise (sense_s.base_hi),
		.i_below_fall (sense_s.base_lo),
		.o_hp_on      (hp_on)
	);

	// Stage selection: Normal uses high-power only, Stop picks by load
	wire stop_m = (mode == ERC_MODE_STOP);
	wire hp_nxt = en_nxt && (!stop_m || hp_on);
	wire lp_nxt = en_nxt && stop_m;

	// Registered drive outputs
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_drive <= '0;
		end else begin
			o_drive.enable    <= en_nxt;
			o_drive.level_3v3 <= is_stand && lvl_r;
			o_drive.hp_stage  <= hp_nxt;
			o_drive.lp_stage  <= lp_nxt;
			o_drive.limit     <= is_stand;
		end
	end

	// Read mux, data in the cycle after the strobe
	logic [7:0] rd_mux;
	always_comb begin
		case (i_addr)
			`ERC_OFF_CTRL:   rd_mux = {6'h00, lvl_r, on_r};
			`ERC_OFF_HWCTRL: rd_mux = {5'h00, uvon_r, stpon_r, ls_r};
			`ERC_OFF_STAT:   rd_mux = {5'h00, fail_r, uv_r, oc_r};
			`ERC_OFF_CFG:    rd_mux = {6'h00, cfg_r};
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_mux : 8'h00;
		end
	end

	// Checks
	a_lock_holds: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		$past(cfg_r) != ERC_CFG_NONE |-> cfg_r == $past(cfg_r))
		else $error("configuration changed after lock");
	a_share_fail: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		chg_share |=> fail_r)
		else $error("failure flag not raised");
	a_stand_nofail: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		is_stand && !fail_r |=> !fail_r)
		else $error("failure flag raised in stand-alone");
	a_share_noflag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		is_share && !oc_r && !uv_r |=> !oc_r && !uv_r)
		else $error("flag set while sharing");
	a_oc_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		oc_set |=> oc_r)
		else $error("overcurrent flag missed");
	a_uv_flag: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		uv_set |=> uv_r)
		else $error("undervoltage flag missed");
	a_init_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		mode == ERC_MODE_INIT || mode == ERC_MODE_FAIL |=> !o_drive.enable)
		else $error("regulator on in INIT or Fail-Safe");
	a_stop_share: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		is_share && stop_m && !stpon_r |=> !o_drive.enable && ls_r)
		else $error("sharing active in Stop");
	a_supply_uv: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		sense_s.supply_uv && !uvon_r |=> !o_drive.enable)
		else $error("regulator on during supply undervoltage");
	a_restart_on: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		is_share && mode == ERC_MODE_RESTART && !sense_s.supply_uv
		|=> o_drive.enable)
		else $error("sharing off in Restart");
	a_level_ignored: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		is_share |=> !o_drive.level_3v3)
		else $error("level select honoured while sharing");
	a_normal_hp: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
		in_norm |=> !o_drive.lp_stage)
		else $error("low-power stage used in Normal");
endmodule

// ### verilog/erc_defines.svh
/*
 Offsets, field positions and reset values of the auxiliary regulator control block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ERC_DEFINES_SVH
`define ERC_DEFINES_SVH

`define ERC_ADDR_W          4
`define ERC_OFF_CTRL        4'h0
`define ERC_OFF_HWCTRL      4'h1
`define ERC_OFF_STAT        4'h2
`define ERC_OFF_CFG         4'h3
`define ERC_CTRL_ON_BIT     0
`define ERC_CTRL_LVL_BIT    1
`define ERC_HW_LS_BIT       0
`define ERC_HW_STPON_BIT    1
`define ERC_HW_UVON_BIT     2
`define ERC_STAT_OC_BIT     0
`define ERC_STAT_UV_BIT     1
`define ERC_STAT_FAIL_BIT   2
`define ERC_CTRL_RST        8'h00
`define ERC_HW_RST          8'h00
`define ERC_SYNC_STAGES     2

`endif

// ### verilog/erc_pkg.sv
/*
 Types shared by the auxiliary regulator control block.
 Assumes the defines header is compiled with it.
*/
package erc_pkg;
	typedef enum logic [2:0] {
		ERC_MODE_INIT    = 3'b000,
		ERC_MODE_NORMAL  = 3'b001,
		ERC_MODE_STOP    = 3'b010,
		ERC_MODE_SLEEP   = 3'b011,
		ERC_MODE_RESTART = 3'b100,
		ERC_MODE_FAIL    = 3'b101
	} erc_mode_e;

	typedef enum logic [1:0] {
		ERC_CFG_NONE  = 2'b00,
		ERC_CFG_STAND = 2'b01,
		ERC_CFG_SHARE = 2'b10
	} erc_cfg_e;

	// Analog sense levels from the regulator front end
	typedef struct packed {
		logic supply_uv;
		logic shunt_hit;
		logic out_uv;
		logic base_hi;
		logic base_lo;
	} erc_sense_s;

	// Drive toward the regulator front end
	typedef struct packed {
		logic enable;
		logic level_3v3;
		logic hp_stage;
		logic lp_stage;
		logic limit;
	} erc_drive_s;
endpackage

// ### verilog/erc_sync.sv
/*
 Two-flop synchroniser for a group of asynchronous levels.
 Assumes inputs come from analog comparators outside the clock domain.
*/
`timescale 1ns/1ns
`include "erc_defines.svh"
module erc_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule

// ### verilog/erc_hyst.sv
/*
 High-power stage selector with hysteresis on base drive current.
 Assumes rising and falling comparator levels are already synchronised.
*/
`timescale 1ns/1ns
module erc_hyst (
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_stop,
	input  wire logic i_above_rise,
	input  wire logic i_below_fall,
	output logic      o_hp_on
);
	// Clear outside Stop; in Stop set above rising threshold, clear below falling, hold in between
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_hp_on <= 1'b0;
		end else if (!i_stop) begin
			o_hp_on <= 1'b0;
		end else if (i_above_rise) begin
			o_hp_on <= 1'b1;
		end else if (i_below_fall) begin
			o_hp_on <= 1'b0;
		end
	end
endmodule

// ### bench/test_erc_top.sv
/*
 Self-checking bench for the auxiliary regulator control block.
 Assumes the design files and the package are compiled before this file.
*/
`timescale 1ns/1ns
`include "erc_defines.svh"
module test_erc_top;
	import erc_pkg::*;
	logic       i_core_clk      = 1'b0;
	logic       i_sys_rst       = 1'b1;
	logic       i_wr            = 1'b0;
	logic       i_rd            = 1'b0;
	logic [2:0] i_chip_mode     = 3'h0;
	erc_sense_s i_sense         = '0;
	logic [3:0] i_addr          = 4'h0;
	logic [7:0] i_wdata         = 8'h00;
	logic [7:0] o_rdata;
	erc_drive_s o_drive;
	int         err_total       = 0;
	int         samples_checked = 0;
	logic [2:0] m;
	logic       s;

	erc_top erc_top_i (
		.i_core_clk  (i_core_clk),
		.i_sys_rst   (i_sys_rst),
		.i_chip_mode (i_chip_mode),
		.i_sense     (i_sense),
		.i_addr      (i_addr),
		.i_wdata     (i_wdata),
		.i_wr        (i_wr),
		.i_rd        (i_rd),
		.o_rdata     (o_rdata),
		.o_drive     (o_drive)
	);

	// 25 MHz core clock
	always #20 i_core_clk = ~i_core_clk;

	// Expected enable of a sharing regulator per chip mode
	function automatic logic exp_share(input logic [2:0] md, input logic stp);
		return (md == 3'h1) || (md == 3'h4) || ((md == 3'h2) && stp);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_en(input logic e);
		chk({7'h00, o_drive.enable}, {7'h00, e});
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_core_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		@(negedge i_core_clk);
		chk(o_rdata, exp);
	endtask

	task automatic mode(input logic [2:0] md);
		@(posedge i_core_clk);
		i_chip_mode <= md;
		repeat (3) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask

	// Sense levels pass a two-flop synchroniser first
	task automatic sense(input logic [4:0] v);
		@(posedge i_core_clk);
		i_sense <= v;
		repeat (5) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask

	task automatic por();
		@(posedge i_core_clk);
		i_sys_rst <= 1'b1;
		repeat (10) @(posedge i_core_clk);
		chk({3'h0, o_drive}, 8'h00);
		i_sys_rst <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task automatic conclude();
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hung sequence
	initial begin
		#(40 * 20000);
		err_total++;
		conclude();
	end

	// Main sequence: stand-alone first, then a fresh power-on into sharing
	initial begin
		void'($urandom(32'h50e085b4));
		por();
		rdchk(4'h3, 8'h00);
		mode(3'h1);
		wr(4'h0, 8'h03);
		rdchk(4'h3, 8'h01);
		chk({7'h00, o_drive.level_3v3}, 8'h01);
		chk({6'h00, o_drive.hp_stage, o_drive.lp_stage}, 8'h02);
		wr(4'h1, 8'h01);
		rdchk(4'h3, 8'h01);
		rdchk(4'h2, 8'h00);
		for (int i = 0; i < 6; i++) begin
			mode(i[2:0]);
			chk_en(!(i == 0 || i == 5));
		end
		mode(3'h1);
		wr(4'h0, 8'h00);
		chk_en(1'b0);
		mode(3'h2);
		chk_en(1'b0);
		mode(3'h1);
		wr(4'h0, 8'h01);
		chk_en(1'b1);
		chk({7'h00, o_drive.level_3v3}, 8'h00);
		mode(3'h2);
		sense(5'h02);
		chk({7'h00, o_drive.hp_stage}, 8'h01);
		chk({6'h00, o_drive.hp_stage, o_drive.lp_stage}, 8'h03);
		sense(5'h00);
		chk({7'h00, o_drive.hp_stage}, 8'h01);
		sense(5'h01);
		chk({7'h00, o_drive.hp_stage}, 8'h00);
		mode(3'h1);
		sense(5'h08);
		rdchk(4'h2, 8'h01);
		chk({7'h00, o_drive.limit}, 8'h01);
		wr(4'h2, 8'h01);
		rdchk(4'h2, 8'h01);
		sense(5'h00);
		wr(4'h2, 8'h01);
		rdchk(4'h2, 8'h00);
		sense(5'h04);
		rdchk(4'h2, 8'h02);
		sense(5'h00);
		wr(4'h2, 8'h02);
		sense(5'h10);
		chk_en(1'b0);
		wr(4'h1, 8'h04);
		chk_en(1'b1);
		wr(4'h1, 8'h00);
		sense(5'h00);
		chk_en(1'b1);
		rdchk(4'hF, 8'h00);
		por();
		mode(3'h1);
		wr(4'h1, 8'h01);
		rdchk(4'h3, 8'h02);
		chk_en(1'b1);
		wr(4'h0, 8'h02);
		chk({7'h00, o_drive.level_3v3}, 8'h00);
		wr(4'h0, 8'h01);
		rdchk(4'h2, 8'h04);
		rdchk(4'h3, 8'h02);
		wr(4'h2, 8'h04);
		sense(5'h0C);
		rdchk(4'h2, 8'h00);
		sense(5'h00);
		for (int i = 0; i < 24; i++) begin
			s = 1'($urandom % 2);
			m = 3'($urandom % 6);
			mode(3'h1);
			wr(4'h1, {6'h00, s, 1'b1});
			mode(m);
			chk_en(exp_share(m, s));
			rdchk(4'h1, {6'h00, s, 1'b1});
		end
		conclude();
	end
endmodule
